// ### verilog/trunk_bind_pkg.sv
// Purpose: Shared constants and carriers for port binding and trunking
// Assumes: 26 ports, 250 MHz ref_clk, APB register access
// Notes: Ports are numbered 0..25 here (front panel port 1 is 0)
package trunk_bind_pkg;
  localparam int NPORTS = 26;
  localparam int NENTRY = 3;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_BSEL = 8'h08;
  localparam logic [7:0] OFF_MACLO = 8'h0c;
  localparam logic [7:0] OFF_MACHI = 8'h10;
  localparam logic [7:0] OFF_BINDEN = 8'h14;
  localparam logic [7:0] OFF_TRUNK = 8'h18;
  localparam logic [7:0] OFF_FLCTRL = 8'h1c;
  localparam logic [7:0] OFF_FLDATA = 8'h20;
  localparam logic [7:0] OFF_ACTMEM = 8'h24;
  // Field positions
  localparam int CTRL_COMMIT = 0;
  localparam int FL_START = 0;
  localparam int FL_FINISH = 1;
  localparam int MACHI_VALID = 16;
  localparam int TR_MODE = 10;
  localparam int TR_HASH = 13;
  localparam int TR_BITS = 15;
  // Reset values
  localparam logic [TR_BITS-1:0] TRUNK_RST = 15'h0000;
  localparam logic [NPORTS-1:0] BINDEN_RST = 26'h0000000;
  // Group layout: first port of each group
  localparam logic [4:0] G0_BASE = 5'h00;
  localparam logic [4:0] G1_BASE = 5'h04;
  localparam logic [4:0] G2_BASE = 5'h18;
  // Update time limit
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned UPDATE_S = 45;
  localparam longint unsigned UPDATE_CYC = UPDATE_S * CLK_HZ;
  // Hash key selection
  typedef enum logic [1:0] {KEY_PORT, KEY_SA, KEY_DA, KEY_SADA} hash_key_e;
  typedef enum {FL_IDLE, FL_ERASE, FL_PROG, FL_DONE} flash_e;
  // Frame descriptor in, forwarding decision out
  typedef struct packed {
    logic [4:0] inPort;
    logic [4:0] outPort;
    logic toTrunk;
    logic [1:0] grp;
    logic [47:0] sa;
    logic [47:0] da;
  } frame_s;
  typedef struct packed {
    logic admit;
    logic egressOk;
    logic [4:0] egress;
  } decision_s;
endpackage : trunk_bind_pkg

// ### verilog/port_trunk_mac_binding.sv
// Purpose: Source MAC binding, trunk member selection, flash update flow
// Assumes: Synchronous active-high reset; lacpAgree from same-clock logic
// Notes: Image data passes a FIFO; flash drains it only after erase
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module image_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  // Full and empty from pointer wrap bit
  assign inReady = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData = mem[rdPtr[AW-1:0]];
  // Storage write
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr[AW-1:0]] <= inData;
  end
  // Pointers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (pop)
        rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : image_fifo

module port_trunk_mac_binding
  import trunk_bind_pkg::*;
#(
  parameter logic [35:0] UPDATE_CYCLES = 36'(UPDATE_CYC)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame descriptor stream
  input wire logic frameValid,
  output logic frameReady,
  input wire frame_s frame,
  output logic decValid,
  input wire logic decReady,
  output decision_s dec,
  // Link state and negotiation
  input wire logic [NPORTS-1:0] linkUpPin,
  input wire logic [NPORTS-1:0] lacpAgree,
  output logic [NPORTS-1:0] lacpTxEn,
  // Flash controller
  input wire logic imageValidPin,
  output logic flashErase,
  input wire logic flashEraseDone,
  output logic flashDataValid,
  input wire logic flashDataReady,
  output logic [31:0] flashData,
  output logic updateMode,
  output logic updateDone,
  output logic restartReq
);
  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  logic [48:0] pendMac [0:NPORTS-1][0:NENTRY-1];
  logic [48:0] actMac [0:NPORTS-1][0:NENTRY-1];
  logic [NPORTS-1:0] pendEn;
  logic [NPORTS-1:0] actEn;
  logic [TR_BITS-1:0] pendTrunk;
  logic [TR_BITS-1:0] actTrunk;
  logic [4:0] selPort;
  logic [1:0] selEntry;
  logic [NPORTS-1:0] linkMeta;
  logic [NPORTS-1:0] linkUp;
  logic imgMeta;
  logic imgSync;
  logic [1:0] bootCnt;
  logic imageOk;
  logic updFail;
  logic finishReq;
  logic [35:0] updTimer;
  flash_e flState;
  flash_e next_flState;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire isData = (paddr == OFF_FLDATA);
  wire mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_BSEL)
    || (paddr == OFF_MACLO) || (paddr == OFF_MACHI) || (paddr == OFF_BINDEN)
    || (paddr == OFF_TRUNK) || (paddr == OFF_FLCTRL) || isData
    || (paddr == OFF_ACTMEM);
  wire fifoInReady;
  wire fifoTake = (flState == FL_ERASE) || (flState == FL_PROG);
  // Wait state only in the access phase, never while idle or in setup
  wire dataStall = access && pwrite && isData && fifoTake && !fifoInReady;
  wire wrDone = access && pwrite && !dataStall;
  wire wrCtrl = wrDone && (paddr == OFF_CTRL);
  wire wrFl = wrDone && (paddr == OFF_FLCTRL);
  wire selOk = (selPort < 5'(NPORTS)) && (selEntry < 2'(NENTRY));
  wire commit = wrCtrl && pwdata[CTRL_COMMIT];
  wire flStart = wrFl && pwdata[FL_START] && (flState == FL_IDLE); // Start ignored unless idle
  wire flFinish = wrFl && pwdata[FL_FINISH];
  wire [48:0] selMac = selOk ? pendMac[selPort][selEntry] : 49'h0;

  // Bus answer: wait state only on a full FIFO during update, error on an unmapped address
  assign pready = !dataStall;
  assign pslverr = access && !mapped;

  // Read data captured in setup phase
  logic [31:0] rdMux;
  wire [2:0] grpValid;
  wire [NPORTS-1:0] actMember;
  always_comb
  begin
    rdMux = 32'h0;
    unique case (paddr)
      OFF_STATUS: rdMux = {24'h0, grpValid, updFail, imageOk, flState == FL_PROG,
        flState == FL_ERASE, updateMode};
      OFF_BSEL: rdMux = {24'h0, 2'(selEntry), 1'b0, selPort};
      OFF_MACLO: rdMux = selMac[31:0];
      OFF_MACHI: rdMux = {15'h0, selMac[48:32]};
      OFF_BINDEN: rdMux = {6'h0, pendEn};
      OFF_TRUNK: rdMux = {17'h0, pendTrunk};
      OFF_ACTMEM: rdMux = {6'h0, actMember};
      default: rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prdata <= 32'h0;
    else if (setup)
      prdata <= pwrite ? 32'h0 : rdMux;
  end

  // ----------------------------------------
  // Pending edits and commit
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      selPort <= 5'h00;
      selEntry <= 2'h0;
      pendEn <= BINDEN_RST;
      pendTrunk <= TRUNK_RST;
    end
    else if (wrDone)
    begin
      if (paddr == OFF_BSEL)
      begin
        selPort <= pwdata[4:0];
        selEntry <= pwdata[7:6];
      end
      if (paddr == OFF_BINDEN)
        pendEn <= pwdata[NPORTS-1:0];
      if (paddr == OFF_TRUNK)
        pendTrunk <= pwdata[TR_BITS-1:0];
    end
  end

  // Binding list edits for the selected port and entry
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int p = 0; p < NPORTS; p++)
        for (int e = 0; e < NENTRY; e++)
          pendMac[p][e] <= 49'h0;
    end
    else if (wrDone && selOk)
    begin
      if (paddr == OFF_MACLO)
        pendMac[selPort][selEntry][31:0] <= pwdata;
      if (paddr == OFF_MACHI)
        pendMac[selPort][selEntry][48:32] <= pwdata[MACHI_VALID:0];
    end
  end

  // All pending settings copied together on commit
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      actEn <= BINDEN_RST;
      actTrunk <= TRUNK_RST;
      for (int p = 0; p < NPORTS; p++)
        for (int e = 0; e < NENTRY; e++)
          actMac[p][e] <= 49'h0;
    end
    else if (commit)
    begin
      actEn <= pendEn;
      actTrunk <= pendTrunk;
      actMac <= pendMac;
    end
  end

  // ----------------------------------------
  // Link state and image pin synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      linkMeta <= '0;
      linkUp <= '0;
      imgMeta <= 1'b0;
      imgSync <= 1'b0;
    end
    else
    begin
      linkMeta <= linkUpPin;
      linkUp <= linkMeta;
      imgMeta <= imageValidPin;
      imgSync <= imgMeta;
    end
  end

  // ----------------------------------------
  // Trunk membership
  // ----------------------------------------
  wire [NPORTS-1:0] cfgMember = {actTrunk[9:8], 16'h0, actTrunk[7:0]};
  wire [2:0] lacpMode = actTrunk[TR_MODE+2:TR_MODE];
  function automatic logic [2:0] pop4(input logic [3:0] m);
    pop4 = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction : pop4
  assign grpValid[0] = pop4(actTrunk[3:0]) >= 3'd2;
  assign grpValid[1] = pop4(actTrunk[7:4]) >= 3'd2;
  assign grpValid[2] = pop4({2'b0, actTrunk[9:8]}) >= 3'd2;
  wire [NPORTS-1:0] grpOf0 = {22'h0, {4{grpValid[0]}}};
  wire [NPORTS-1:0] grpOf1 = {18'h0, {4{grpValid[1]}}, 4'h0};
  wire [NPORTS-1:0] grpOf2 = {{2{grpValid[2]}}, 24'h0};
  wire [NPORTS-1:0] inGrp = cfgMember & (grpOf0 | grpOf1 | grpOf2);
  wire [NPORTS-1:0] negot = {{2{lacpMode[2]}}, 16'h0, {4{lacpMode[1]}}, {4{lacpMode[0]}}};
  // Static joins at once, negotiated waits for agreement
  assign lacpTxEn = inGrp & negot;
  assign actMember = inGrp & linkUp & (~negot | lacpAgree);

  // ----------------------------------------
  // Hash and member pick
  // ----------------------------------------
  function automatic logic [7:0] fold(input logic [47:0] v);
    fold = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
  endfunction : fold
  function automatic logic [1:0] nthSet(input logic [3:0] m, input logic [1:0] n);
    logic [2:0] seen;
    seen = 3'h0;
    nthSet = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (m[i] && (seen == {1'b0, n}))
        nthSet = 2'(i);
      if (m[i])
        seen = seen + 3'h1;
    end
  endfunction : nthSet

  wire [1:0] keySel = actTrunk[TR_HASH+1:TR_HASH];
  logic [7:0] hashVal;
  always_comb
  begin
    unique case (hash_key_e'(keySel))
      KEY_PORT: hashVal = {3'h0, frame.inPort};
      KEY_SA: hashVal = fold(frame.sa);
      KEY_DA: hashVal = fold(frame.da);
      KEY_SADA: hashVal = fold(frame.sa ^ frame.da);
    endcase
  end
  wire [3:0] liveMask = (frame.grp == 2'd0) ? actMember[3:0]
    : (frame.grp == 2'd1) ? actMember[7:4] : {2'b0, actMember[25:24]};
  wire [4:0] grpBase = (frame.grp == 2'd0) ? G0_BASE
    : (frame.grp == 2'd1) ? G1_BASE : G2_BASE;
  wire [2:0] liveCnt = pop4(liveMask);
  wire grpUsable = (frame.grp != 2'd3) && grpValid[frame.grp] && (liveCnt != 3'd0);
  wire [7:0] cntWide = {5'h0, liveCnt};
  wire [7:0] modVal = (liveCnt == 3'd0) ? 8'h0 : (hashVal % cntWide);
  wire [1:0] pickIdx = modVal[1:0];
  wire [4:0] trunkPort = grpBase + {3'h0, nthSet(liveMask, pickIdx)};

  // ----------------------------------------
  // Source binding check
  // ----------------------------------------
  wire inOk = frame.inPort < 5'(NPORTS);
  logic macHit;
  always_comb
  begin
    macHit = 1'b0;
    for (int e = 0; e < NENTRY; e++)
      if (inOk && actMac[frame.inPort][e][48] && (actMac[frame.inPort][e][47:0] == frame.sa))
        macHit = 1'b1;
  end
  wire bindOn = inOk && actEn[frame.inPort];
  wire admitNow = inOk && (!bindOn || macHit);

  // Registered decision stage
  assign frameReady = !decValid || decReady;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      decValid <= 1'b0;
      dec <= '0;
    end
    else if (frameReady)
    begin
      decValid <= frameValid;
      dec.admit <= admitNow;
      dec.egressOk <= frame.toTrunk ? grpUsable : 1'b1;
      dec.egress <= frame.toTrunk ? trunkPort : frame.outPort;
    end
  end

  // ----------------------------------------
  // Firmware image path
  // ----------------------------------------
  wire fifoOutValid;
  wire [31:0] fifoOut;
  wire drain = (flState == FL_PROG);
  image_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(wrDone && isData && fifoTake),
    .inReady(fifoInReady),
    .inData(pwdata),
    .outValid(fifoOutValid),
    .outReady(drain && flashDataReady),
    .outData(fifoOut)
  );
  assign flashDataValid = drain && fifoOutValid;
  assign flashData = fifoOut;
  assign flashErase = (flState == FL_ERASE);
  assign updateMode = !imageOk;
  assign updateDone = (flState == FL_DONE);
  assign restartReq = (flState == FL_DONE);
  wire overTime = updTimer >= UPDATE_CYCLES;

  // Update sequencer
  always_comb
  begin
    next_flState = flState;
    unique case (flState)
      FL_IDLE: if (flStart) next_flState = FL_ERASE;
      FL_ERASE:
        if (overTime)
          next_flState = FL_IDLE;
        else if (flashEraseDone)
          next_flState = FL_PROG;
      FL_PROG:
        if (overTime)
          next_flState = FL_IDLE;
        else if (finishReq && !fifoOutValid)
          next_flState = FL_DONE;
      FL_DONE: next_flState = FL_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      flState <= FL_IDLE;
    else
      flState <= next_flState;
  end

  // Image status, timer and finish request
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bootCnt <= 2'h0;
      imageOk <= 1'b0;
      updFail <= 1'b0;
      finishReq <= 1'b0;
      updTimer <= 36'h0;
    end
    else
    begin
      // Capture the synced image pin once, after both sync stages filled
      if (bootCnt != 2'h3)
        bootCnt <= bootCnt + 2'h1;
      if (bootCnt == 2'h2)
        imageOk <= imgSync;
      else if (flState == FL_DONE)
        imageOk <= 1'b1;
      else if (flStart)
        imageOk <= 1'b0;
      if (flStart)
        updFail <= 1'b0;
      else if (fifoTake && overTime)
        updFail <= 1'b1;
      finishReq <= fifoTake && (finishReq || flFinish);
      updTimer <= fifoTake ? updTimer + 36'h1 : 36'h0;
    end
  end
endmodule : port_trunk_mac_binding

// ### verif/port_trunk_mac_binding_chk.sv
// Purpose: Port-level assertions for port_trunk_mac_binding
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the design at the foot of this file
`timescale 1ns/1ps
module port_trunk_mac_binding_chk
  import trunk_bind_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Frame stream
  input wire logic frameValid,
  input wire logic frameReady,
  input wire logic decValid,
  input wire logic decReady,
  input wire decision_s dec,
  // Flash side
  input wire logic flashErase,
  input wire logic flashDataValid,
  input wire logic flashDataReady,
  input wire logic [31:0] flashData,
  input wire logic updateMode,
  input wire logic updateDone,
  input wire logic restartReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ------------------------------
  // Sequences
  // ------------------------------
  sequence sTaken;
    frameValid && frameReady;
  endsequence
  sequence sFinish;
    updateDone && restartReq;
  endsequence
  // Decision path
  AST_DEC_LATENCY: assert property (sTaken |=> decValid)
    else $error("no decision after accepted frame");
  AST_DEC_HOLD: assert property (decValid && !decReady |=> decValid && $stable(dec))
    else $error("decision changed while stalled");
  AST_READY_RULE: assert property (frameReady == (!decValid || decReady))
    else $error("frame ready disagrees with decision slot");
  // Flash sequencing
  AST_ERASE_FIRST: assert property (flashDataValid |-> !flashErase)
    else $error("image data offered during erase");
  AST_FLASH_HOLD: assert property (flashDataValid && !flashDataReady |=>
    flashDataValid && $stable(flashData))
    else $error("flash word changed while stalled");
  AST_DONE_PULSE: assert property (updateDone |-> sFinish ##1 !updateDone && !restartReq)
    else $error("completion pulse malformed");
  AST_IMAGE_OK: assert property (sFinish |-> ##[1:3] !updateMode)
    else $error("update mode kept after completion");
  AST_UPDATE_MODE: assert property ($rose(flashErase) |-> ##[0:2] updateMode)
    else $error("update mode not set during erase");
  // Register bus
  AST_STALL_CAUSE: assert property (!pready |->
    psel && penable && pwrite && paddr == OFF_FLDATA)
    else $error("wait state outside image write");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
endmodule : port_trunk_mac_binding_chk

bind port_trunk_mac_binding port_trunk_mac_binding_chk chk (.ref_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .frameValid, .frameReady, .decValid,
  .decReady, .dec, .flashErase, .flashDataValid, .flashDataReady, .flashData,
  .updateMode, .updateDone, .restartReq);

// ### verif/flash_peer_model.sv
// Purpose: Flash device and link peer behind the block
// Assumes: Same clock as the design
// Notes: hold stalls erase and data; peerMute refuses agreement
`timescale 1ns/1ps
module flash_peer_model
  import trunk_bind_pkg::*;
#(
  parameter int ERASE_CYC = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bench control
  input wire logic hold,
  input wire logic [NPORTS-1:0] peerMute,
  // Flash
  input wire logic flashErase,
  output logic flashEraseDone,
  input wire logic flashDataValid,
  output logic flashDataReady,
  input wire logic [31:0] flashData,
  // Negotiation
  input wire logic [NPORTS-1:0] lacpTxEn,
  output logic [NPORTS-1:0] lacpAgree
);
  int eraseCnt;
  logic [NPORTS-1:0] heard;
  logic [31:0] got[$];
  // Erase timer, stalling sink, and peer agreement
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      eraseCnt <= 0;
      flashEraseDone <= 1'b0;
      flashDataReady <= 1'b0;
      heard <= '0;
      lacpAgree <= '0;
    end
    else
    begin
      eraseCnt <= flashErase ? eraseCnt + 1 : 0;
      flashEraseDone <= flashErase && !hold && eraseCnt >= ERASE_CYC;
      flashDataReady <= !hold && !flashDataReady; // Stall every other cycle
      if (flashDataValid && flashDataReady)
        got.push_back(flashData);
      heard <= lacpTxEn;
      lacpAgree <= heard & lacpTxEn & ~peerMute;
    end
  end
endmodule : flash_peer_model

// ### verif/port_trunk_mac_binding_tb.sv
// Purpose: Directed bench for port_trunk_mac_binding
// Assumes: APB master tasks; flash peer model beside the design
// Notes: Short update limit so the run stays brief
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module port_trunk_mac_binding_tb
  import trunk_bind_pkg::*;
;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, flashData, rd;
  logic pready, pslverr, err, frameReady, decValid, decReady = 0, frameValid = 0;
  frame_s frame = '0;
  decision_s dec, d;
  logic [NPORTS-1:0] linkUpPin = '1, lacpAgree, lacpTxEn, peerMute = '0;
  logic imageValidPin = 0, flashErase, flashEraseDone, flashDataValid, flashDataReady;
  logic updateMode, updateDone, restartReq, hold = 0;
  int n_mismatch = 0, checked = 0, i, k, h;
  port_trunk_mac_binding #(.UPDATE_CYCLES(36'd2000)) dut (.*);
  flash_peer_model peer (.*);
  always #2 ref_clk = ~ref_clk;
  // ------------------------------
  // Bus and stream tasks
  // ------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1;
    @(posedge ref_clk);
    while (!pready) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic send(input logic [4:0] ip, input logic t, input logic [1:0] g,
                      input logic [47:0] sa, input logic [47:0] da);
    @(posedge ref_clk);
    frameValid <= 1;
    frame <= '{ip, 5'h00, t, g, sa, da};
    @(posedge ref_clk);
    while (!frameReady) @(posedge ref_clk);
    frameValid <= 0;
    decReady <= 1;
    @(posedge ref_clk);
    while (!decValid) @(posedge ref_clk);
    d = dec;
    decReady <= 0;
  endtask : send
  function automatic logic [7:0] fold(input logic [47:0] m);
    return m[7:0] ^ m[15:8] ^ m[23:16] ^ m[31:24] ^ m[39:32] ^ m[47:40];
  endfunction : fold
  // Expected egress: idx-th live member from the group base
  function automatic logic [4:0] pick(input logic [3:0] live, input logic [4:0] b, input int h);
    int j;
    j = h % $countones(live);
    for (int q = 0; q < 4; q++)
    begin
      if (live[q] && j == 0)
        return b + 5'(q);
      if (live[q])
        j--;
    end
    return 5'h1f;
  endfunction : pick
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial
  begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 0;
    apb(0, OFF_TRUNK, 0); `CHK(rd, 32'h0)
    apb(0, OFF_BINDEN, 0); `CHK(rd, 32'h0)
    apb(0, 8'h28, 0); `CHK(err, 1'b1)
    apb(0, OFF_STATUS, 0); `CHK(rd[0], 1'b1)
    // Binding: pending until commit, then filter
    apb(1, OFF_BSEL, 32'h02);
    apb(1, OFF_MACLO, 32'h33445566);
    apb(1, OFF_MACHI, 32'h00011122);
    apb(1, OFF_BSEL, 32'h82);
    apb(1, OFF_MACLO, 32'h77);
    apb(1, OFF_MACHI, 32'h00010000);
    apb(1, OFF_BINDEN, 32'h4);
    send(2, 0, 0, 48'h0a, 0); `CHK(d.admit, 1'b1)
    apb(1, OFF_CTRL, 32'h1);
    send(2, 0, 0, 48'h0a, 0); `CHK(d.admit, 1'b0)
    send(2, 0, 0, 48'h112233445566, 0); `CHK(d.admit, 1'b1)
    send(2, 0, 0, 48'h77, 0); `CHK(d.admit, 1'b1)
    send(3, 0, 0, 48'h0a, 0); `CHK(d.admit, 1'b1)
    apb(1, OFF_BSEL, 32'hc2);
    apb(1, OFF_MACLO, 32'h1);
    apb(0, OFF_MACLO, 0); `CHK(rd, 32'h0)
    // Trunk: every hash key, one-member group refused
    for (k = 0; k < 4; k++)
    begin
      apb(1, OFF_TRUNK, 32'h107 | (k << 13));
      apb(1, OFF_CTRL, 32'h1);
      send(5, 1, 0, 48'h123456789abc, 48'h0f1e2d3c4b5a);
      h = k == 0 ? 5 : k == 1 ? fold(48'h123456789abc) : k == 2 ? fold(48'h0f1e2d3c4b5a)
        : fold(48'h123456789abc) ^ fold(48'h0f1e2d3c4b5a);
      `CHK(d.egress, pick(4'h7, G0_BASE, h))
    end
    apb(0, OFF_ACTMEM, 0); `CHK(rd, 32'h7)
    `CHK(lacpTxEn, 26'h0)
    send(3, 1, 2, 0, 0); `CHK(d.egressOk, 1'b0)
    // Failover and return of member 1, hash on port
    apb(1, OFF_TRUNK, 32'h107);
    apb(1, OFF_CTRL, 32'h1);
    send(4, 1, 0, 0, 0); `CHK(d.egress, 5'd1)
    linkUpPin[1] <= 0;
    repeat (5) @(posedge ref_clk);
    send(4, 1, 0, 0, 0); `CHK(d.egress, pick(4'h5, G0_BASE, 4))
    linkUpPin[1] <= 1;
    repeat (5) @(posedge ref_clk);
    send(4, 1, 0, 0, 0); `CHK(d.egress, 5'd1)
    // Groups one and two
    apb(1, OFF_TRUNK, 32'h3f0);
    apb(1, OFF_CTRL, 32'h1);
    send(6, 1, 1, 0, 0); `CHK(d.egress, pick(4'hf, G1_BASE, 6))
    send(3, 1, 2, 0, 0); `CHK(d.egress, 5'd25)
    send(3, 1, 0, 0, 0); `CHK(d.egressOk, 1'b0)
    // Negotiated group zero, peer refuses port 1
    peerMute <= 26'h2;
    apb(1, OFF_TRUNK, 32'h407);
    apb(1, OFF_CTRL, 32'h1);
    repeat (6) @(posedge ref_clk);
    `CHK(lacpTxEn[2:0], 3'b111)
    apb(0, OFF_ACTMEM, 0); `CHK(rd[3:0], 4'h5)
    // Update: fill buffer during erase until it refuses
    hold <= 1;
    apb(1, OFF_FLCTRL, 32'h1);
    apb(0, OFF_STATUS, 0); `CHK(rd[1], 1'b1)
    for (i = 0; i < 32; i++)
      apb(1, OFF_FLDATA, 32'ha000 + i);
    fork
      apb(1, OFF_FLDATA, 32'ha020);
      begin
        repeat (10) @(posedge ref_clk);
        `CHK(pready, 1'b0)
        `CHK(peer.got.size(), 0)
        hold <= 0;
      end
    join
    apb(1, OFF_FLCTRL, 32'h2);
    i = 0;
    while (updateDone !== 1'b1 && i < 3000)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    `CHK(restartReq, 1'b1)
    `CHK(peer.got.size(), 33)
    for (i = 0; i < 33 && i < peer.got.size(); i++)
      `CHK(peer.got[i], 32'ha000 + i)
    apb(0, OFF_STATUS, 0); `CHK(rd[0], 1'b0)
    // Power-on with a complete image leaves update mode off
    imageValidPin <= 1;
    reset <= 1;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    repeat (4) @(posedge ref_clk);
    apb(0, OFF_STATUS, 0); `CHK(rd[3:0], 4'h8)
    end_of_test();
  end
endmodule : port_trunk_mac_binding_tb
